// File: design/mmo_decoder.sv
// Purpose: reset sequencing and program/data/IO/byte space decoding with overlays
// Assumes: core requests on one clock; external data and strap pins are asynchronous
// Notes: external strobes last wait states plus two synchroniser cycles plus one
`timescale 1ns/1ps

// Overview of operation
// - Reset empties stacks, masks interrupts, clears mode
// - Boot only when configured and no bus request
// - After boot, fetch starts at address zero
// - Later resets need no clock settling time
// - Program RAM 8K by 24, two ports
// - Program overlay one or two sends upper half external
// - Program overlay two sets address bit 13
// - Overlay selects never stacked, loops ignore them
// - Mode B: no boot, low program half external
// - Data RAM 8160 words, 32 control registers
// - Data overlay one or two sends low half external
// - Data overlay two sets address bit 13
// - On-chip accesses finish in one cycle
// - External data accesses take programmed wait states
// - IO space 2048 words, upper bits driven zero
// - Four IO wait settings, zero to seven
// - IO wait setting chosen by address region
// - Byte space forms 22-bit address with data lines
module mmo_decoder (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                boot_cfg_pin,
  input  wire logic                mode_b_pin,
  input  wire logic                bus_req_pin,
  input  wire logic                boot_done,
  input  wire mmo_pkg::mmo_req_s   core_req,
  output logic                     core_ready,
  output mmo_pkg::mmo_rsp_s        core_rsp,
  input  wire logic                fetch_valid,
  input  wire logic [13:0]         fetch_addr,
  output logic                     fetch_ready,
  output logic                     fetch_ack,
  output logic [23:0]              fetch_data,
  output mmo_pkg::mmo_ext_s        ext,
  input  wire logic [23:0]         ext_din,
  output logic                     run,
  output logic [13:0]              start_pc,
  output logic                     stack_clear,
  output logic [9:0]               int_mask
);
  import mmo_pkg::*;

  typedef enum logic [2:0] {BS_RST = 3'h1, BS_BOOT = 3'h2, BS_RUN = 3'h4} mmo_boot_e;
  typedef enum logic [2:0] {XS_IDLE = 3'h1, XS_STRB = 3'h2, XS_DONE = 3'h4} mmo_xfer_e;

  function automatic logic ovl_ok(input logic [1:0] o);
    return (o == OVL_1) || (o == OVL_2);
  endfunction : ovl_ok

  function automatic logic [AW-1:0] ovl_addr(input logic [1:0] o, input logic [AW-1:0] a);
    return {o == OVL_2, a[OVL_BIT-1:0]};
  endfunction : ovl_addr

  mmo_boot_e                 bs;
  mmo_boot_e                 next_bs;
  mmo_xfer_e                 xs;
  mmo_xfer_e                 next_xs;
  mmo_space_e                xsp;
  logic [2:0]                pin_s1;
  logic [2:0]                pin_s2;
  logic [PW-1:0]             din_s1;
  logic [PW-1:0]             din_s2;
  logic [3:0]                rcnt;
  logic [3:0]                xcnt;
  logic                      mode_b;
  logic [1:0]                povl;
  logic [1:0]                dovl;
  logic [WAIT_W-1:0]         data_ext_wait_count;
  logic [3:0][WAIT_W-1:0]    iowait;
  logic [PMODE_W-1:0]        pmode;
  logic [IMASK_W-1:0]        imask;
  logic [PW-1:0]             pm_mem [PM_WORDS];
  logic [DW-1:0]             dm_mem [DM_WORDS];

  // Registers also seen by the core at the top of data space
  function automatic logic [31:0] reg_rd(input logic [4:0] i);
    if (i == RI_POVL) return 32'(povl);
    else if (i == RI_DOVL) return 32'(dovl);
    else if (i == RI_DATA_EXT_WAIT_COUNT) return 32'(data_ext_wait_count);
    else if (i == RI_IOWAIT) return 32'(iowait);
    else if (i == RI_PMODE) return 32'(pmode);
    else if (i == RI_IMASK) return 32'(imask);
    else if (i == RI_STAT) return 32'({bs, mode_b});
    else return 32'h00000000;
  endfunction : reg_rd

  // Pins pass two flops; nothing reads the first stage
  always_ff @(posedge clk)
  begin
    pin_s1 <= {boot_cfg_pin, mode_b_pin, bus_req_pin};
    pin_s2 <= pin_s1;
    din_s1 <= ext_din;
    din_s2 <= din_s1;
  end

  // Core request decode
  wire [AW-1:0]      a      = core_req.addr[AW-1:0];
  wire [OVL_BIT-1:0] a_lo   = a[OVL_BIT-1:0];
  wire [BAW-1:0]     full_a = core_req.addr;
  wire [1:0]         rgn    = a[RGN_LO+:2];
  wire               is_pm  = core_req.space == SP_PM;
  wire               is_dm  = core_req.space == SP_DM;
  wire               is_io  = core_req.space == SP_IO;
  wire               is_bm  = core_req.space == SP_BYTE;
  wire               take   = core_req.valid && core_ready;
  wire               pm_int = is_pm && !mode_b && !a[OVL_BIT];
  wire               pm_ext = is_pm && (mode_b ? !a[OVL_BIT] : a[OVL_BIT] && ovl_ok(povl));
  wire               dm_reg = is_dm && (a >= DM_REG_LO);
  wire               dm_int = is_dm && a[OVL_BIT] && !dm_reg;
  wire               dm_ext = is_dm && !a[OVL_BIT] && ovl_ok(dovl);
  wire               go_ext = pm_ext || dm_ext || is_io || is_bm;
  wire               bad    = !go_ext && !(pm_int || dm_int || dm_reg);
  wire [AW-1:0]      ext_a  = (is_pm && mode_b) ? a
                            : is_pm ? ovl_addr(povl, a)
                            : is_dm ? ovl_addr(dovl, a)
                            : is_io ? AW'(a[IO_AW-1:0])
                            : a;
  wire [WAIT_W-1:0]  ext_w  = is_dm ? data_ext_wait_count
                            : is_io ? iowait[rgn]
                            : WAIT_NONE;
  wire [PW-1:0]      ext_d  = is_pm ? core_req.wdata
                            : is_bm ? {full_a[BAW-1:AW], core_req.wdata[7:0], 8'h00}
                            : {core_req.wdata[DW-1:0], 8'h00};
  wire [2:0]         ext_oe = core_req.write ? (is_pm ? OE_ALL : OE_HI16)
                            : is_bm ? OE_PAGE : OE_NONE;
  wire               x_last = (xs == XS_STRB) && (xcnt == 4'h0);

  // APB slave: read data is latched in the setup cycle, so pready is always high
  wire [4:0]         apb_idx = paddr[IDX_HI:IDX_LO];
  wire               apb_bad = paddr[APB_AW-1] || (apb_idx > RI_STAT);
  wire               apb_wr  = psel && penable && pwrite && !apb_bad;
  wire               core_wr = take && dm_reg && core_req.write;
  wire [4:0]         wr_idx  = apb_wr ? apb_idx : a[4:0];
  wire [31:0]        wr_dat  = apb_wr ? pwdata : 32'(core_req.wdata);

  assign pready = 1'b1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= apb_bad ? 32'h00000000 : reg_rd(apb_idx);
      pslverr <= apb_bad;
    end
  end

  // Overlay selects have no stack copy; software saves them itself
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      povl   <= 2'h0;
      dovl   <= 2'h0;
      data_ext_wait_count  <= WAIT_NONE;
      iowait <= 12'h000;
      pmode  <= 7'h00;
      imask  <= 10'h000;
    end
    else if (apb_wr || core_wr)
    begin
      if (wr_idx == RI_POVL) povl <= wr_dat[1:0];
      else if (wr_idx == RI_DOVL) dovl <= wr_dat[1:0];
      else if (wr_idx == RI_DATA_EXT_WAIT_COUNT) data_ext_wait_count <= wr_dat[WAIT_W-1:0];
      else if (wr_idx == RI_IOWAIT) iowait <= wr_dat[4*WAIT_W-1:0];
      else if (wr_idx == RI_PMODE) pmode <= wr_dat[PMODE_W-1:0];
      else if (wr_idx == RI_IMASK) imask <= wr_dat[IMASK_W-1:0];
    end
  end

  // Reset sequencer; no settling count since the clock keeps running
  always_comb
  begin
    next_bs = bs;
    case (bs)
      BS_RST:
        if (rcnt == SYNC_N)
        begin
          if (!pin_s2[PIN_MODE] && pin_s2[PIN_BOOT] && !pin_s2[PIN_BREQ]) next_bs = BS_BOOT;
          else next_bs = BS_RUN;
        end
      BS_BOOT:
        if (boot_done) next_bs = BS_RUN;
      default:
        next_bs = BS_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bs     <= BS_RST;
      rcnt   <= 4'h0;
      mode_b <= 1'b0;
    end
    else
    begin
      bs <= next_bs;
      if (bs == BS_RST && rcnt != SYNC_N) rcnt <= rcnt + 4'h1;
      if (bs == BS_RST && next_bs != BS_RST) mode_b <= pin_s2[PIN_MODE];
    end
  end

  assign run         = bs == BS_RUN;
  assign stack_clear = bs == BS_RST;
  assign start_pc    = PM_START;
  assign int_mask    = imask;
  assign core_ready  = (xs == XS_IDLE) && (bs != BS_RST);
  assign fetch_ready = run && !mode_b && !fetch_addr[OVL_BIT];

  // External access: strobes include two cycles for the data synchroniser
  always_comb
  begin
    next_xs = xs;
    case (xs)
      XS_IDLE: if (take && go_ext) next_xs = XS_STRB;
      XS_STRB: if (xcnt == 4'h0) next_xs = XS_DONE;
      default: next_xs = XS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      xs   <= XS_IDLE;
      xcnt <= 4'h0;
      xsp  <= SP_PM;
      ext  <= EXT_IDLE;
    end
    else
    begin
      xs <= next_xs;
      if (xs == XS_IDLE && take && go_ext)
      begin
        // Overlay and wait values are frozen here for the whole access
        ext.addr <= ext_a;
        ext.pm_n <= !is_pm;
        ext.dm_n <= !is_dm;
        ext.io_n <= !is_io;
        ext.bm_n <= !is_bm;
        ext.rd_n <= core_req.write;
        ext.wr_n <= !core_req.write;
        ext.dout <= ext_d;
        ext.doe  <= ext_oe;
        xcnt     <= 4'({1'b0, ext_w}) + SYNC_N;
        xsp      <= core_req.space;
      end
      else if (xs == XS_STRB)
      begin
        xcnt <= xcnt - 4'h1;
        if (xcnt == 4'h0) ext <= EXT_IDLE;
      end
    end
  end

  // On-chip RAM: the fetch port reads alongside the data port
  always_ff @(posedge clk)
  begin
    if (take && pm_int && core_req.write) pm_mem[a_lo] <= core_req.wdata;
    if (take && dm_int && core_req.write) dm_mem[a_lo] <= core_req.wdata[DW-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetch_ack  <= 1'b0;
      fetch_data <= 24'h000000;
    end
    else
    begin
      fetch_ack <= fetch_valid && fetch_ready;
      if (fetch_valid && fetch_ready) fetch_data <= pm_mem[fetch_addr[OVL_BIT-1:0]];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst) core_rsp <= '0;
    else
    begin
      core_rsp.ack <= (take && !go_ext) || x_last;
      core_rsp.err <= take && bad;
      if (take && !go_ext)
        core_rsp.rdata <= pm_int ? pm_mem[a_lo]
                        : dm_int ? PW'(dm_mem[a_lo])
                        : dm_reg ? PW'(reg_rd(a[4:0]))
                        : 24'h000000;
      else if (x_last)
        core_rsp.rdata <= (xsp == SP_PM) ? din_s2
                        : (xsp == SP_BYTE) ? PW'(din_s2[LANE_LO+:8])
                        : PW'(din_s2[PW-1:LANE_LO]);
    end
  end

  // Checks
  logic [3:0] strb_len;
  always_ff @(posedge clk)
  begin
    if (rst || xs != XS_STRB) strb_len <= 4'h0;
    else strb_len <= strb_len + 4'h1;
  end
  wire [WAIT_W-1:0] exp_w = (xsp == SP_DM) ? data_ext_wait_count
                          : (xsp == SP_IO) ? iowait[ext.addr[RGN_LO+:2]] : WAIT_NONE;

  sequence s_boot_end;
    bs == BS_BOOT && boot_done;
  endsequence
  sequence s_enter_boot;
    bs == BS_RST ##1 bs == BS_BOOT;
  endsequence

  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> pmode == 7'h00 && imask == 10'h000 && stack_clear)
    else $error("reset left mode, mask or stacks set");
  boot_gate_a: assert property (@(posedge clk) disable iff (rst)
    s_enter_boot |-> $past(pin_s2[PIN_BOOT]) && !$past(pin_s2[PIN_BREQ]))
    else $error("boot started without config or with bus request");
  fetch_zero_a: assert property (@(posedge clk) disable iff (rst)
    s_boot_end |=> run && start_pc == PM_START)
    else $error("run not entered at address zero after boot");
  no_settle_a: assert property (@(posedge clk)
    $fell(rst) |-> (bs == BS_RST) [*3] ##1 (bs != BS_RST))
    else $error("reset exit took a settling delay");
  dual_port_a: assert property (@(posedge clk) disable iff (rst)
    (fetch_valid && fetch_ready && take && pm_int) |=> fetch_ack && core_rsp.ack)
    else $error("fetch and data read did not finish together");
  int_one_a: assert property (@(posedge clk) disable iff (rst)
    (take && !go_ext) |=> core_rsp.ack ##1 (!core_rsp.ack || $past(take)))
    else $error("on-chip access not one cycle");
  pm_ovl_a: assert property (@(posedge clk) disable iff (rst)
    (take && pm_ext && !mode_b && povl == OVL_2)
      |=> !ext.pm_n && ext.addr == {1'b1, $past(a_lo)})
    else $error("program overlay two address wrong");
  dm_ovl_a: assert property (@(posedge clk) disable iff (rst)
    (take && dm_ext && dovl == OVL_1) |=> !ext.dm_n && ext.addr == {1'b0, $past(a_lo)})
    else $error("data overlay one address wrong");
  mode_b_a: assert property (@(posedge clk) disable iff (rst)
    (take && is_pm && mode_b && !a[OVL_BIT]) |=> !ext.pm_n && ext.addr == $past(a))
    else $error("mode B program access not external");
  io_addr_a: assert property (@(posedge clk) disable iff (rst)
    (take && is_io) |=> !ext.io_n && ext.addr[AW-1:IO_AW] == 3'h0)
    else $error("IO upper address bits driven");
  ext_wait_a: assert property (@(posedge clk) disable iff (rst)
    (xs == XS_STRB && next_xs == XS_DONE) |-> strb_len == 4'({1'b0, exp_w}) + SYNC_N)
    else $error("external strobe length differs from wait setting");
  byte_addr_a: assert property (@(posedge clk) disable iff (rst)
    (take && is_bm) |=> {ext.dout[PW-1:DW], ext.addr} == $past(full_a))
    else $error("byte address not spread over data lines");
  dm_reg_a: assert property (@(posedge clk) disable iff (rst)
    (take && dm_reg) |=> core_rsp.ack && !core_rsp.err && xs == XS_IDLE)
    else $error("control register window went external");
endmodule : mmo_decoder

// File: design/mmo_pkg.sv
// Purpose: shared constants and types for the memory map overlay decoder
// Assumes: 14-bit core addresses, 24-bit external data bus, APB register access
// Notes: register offsets are word indices; the APB byte address is index times four
package mmo_pkg;
  localparam int unsigned AW       = 14;
  localparam int unsigned BAW      = 22;
  localparam int unsigned PW       = 24;
  localparam int unsigned DW       = 16;
  localparam int unsigned PM_WORDS = 8192;
  localparam int unsigned DM_WORDS = 8160;
  localparam int unsigned WAIT_W   = 3;
  localparam int unsigned PMODE_W  = 7;
  localparam int unsigned IMASK_W  = 10;
  localparam int unsigned APB_AW   = 8;
  localparam int unsigned IDX_LO   = 2;
  localparam int unsigned IDX_HI   = 6;
  localparam int unsigned OVL_BIT  = 13;
  localparam int unsigned IO_AW    = 11;
  localparam int unsigned RGN_LO   = 9;
  localparam int unsigned LANE_LO  = 8;
  localparam int unsigned PIN_BOOT = 2;
  localparam int unsigned PIN_MODE = 1;
  localparam int unsigned PIN_BREQ = 0;
  localparam logic [3:0]  SYNC_N   = 4'h2;
  localparam logic [13:0] PM_START = 14'h0000;
  localparam logic [13:0] DM_REG_LO = 14'h3FE0;
  localparam logic [1:0]  OVL_1    = 2'h1;
  localparam logic [1:0]  OVL_2    = 2'h2;
  localparam logic [2:0]  WAIT_NONE = 3'h0;
  localparam logic [2:0]  OE_NONE  = 3'h0;
  localparam logic [2:0]  OE_PAGE  = 3'h4;
  localparam logic [2:0]  OE_HI16  = 3'h6;
  localparam logic [2:0]  OE_ALL   = 3'h7;
  localparam logic [4:0]  RI_POVL  = 5'h00;
  localparam logic [4:0]  RI_DOVL  = 5'h01;
  localparam logic [4:0]  RI_DATA_EXT_WAIT_COUNT = 5'h02;
  localparam logic [4:0]  RI_IOWAIT = 5'h03;
  localparam logic [4:0]  RI_PMODE = 5'h04;
  localparam logic [4:0]  RI_IMASK = 5'h05;
  localparam logic [4:0]  RI_STAT  = 5'h06;

  typedef enum logic [1:0] {SP_PM = 2'h0, SP_DM = 2'h1, SP_IO = 2'h2, SP_BYTE = 2'h3} mmo_space_e;

  typedef struct packed {
    logic           valid;
    mmo_space_e     space;
    logic           write;
    logic [BAW-1:0] addr;
    logic [PW-1:0]  wdata;
  } mmo_req_s;

  typedef struct packed {
    logic          ack;
    logic          err;
    logic [PW-1:0] rdata;
  } mmo_rsp_s;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic          pm_n;
    logic          dm_n;
    logic          io_n;
    logic          bm_n;
    logic          rd_n;
    logic          wr_n;
    logic [PW-1:0] dout;
    logic [2:0]    doe;
  } mmo_ext_s;

  localparam mmo_ext_s EXT_IDLE = '{addr: 14'h0000, pm_n: 1'b1, dm_n: 1'b1, io_n: 1'b1,
                                    bm_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, dout: 24'h000000,
                                    doe: 3'h0};
endpackage : mmo_pkg

// File: dv/mmo_ext_mem.sv
// Purpose: external overlay memories and IO peripherals behind the decoder
// Assumes: one space strobe low at a time; strobes and read/write active low
// Notes: a released data bus toggles each cycle so stale data never passes as valid
`timescale 1ns/1ps
module mmo_ext_mem (
  input  wire logic              clk,
  input  wire mmo_pkg::mmo_ext_s ext,
  output logic [23:0]            ext_din,
  output logic [13:0]            s_addr,
  output logic [23:0]            s_dout,
  output logic [2:0]             s_oe,
  output logic [1:0]             s_sp,
  output int                     s_len,
  output int                     acc_n
);
  import mmo_pkg::*;
  logic [23:0] mem [65536];
  logic [23:0] rel;
  logic        was;
  logic        act;
  logic [1:0]  sp;
  assign sp  = !ext.pm_n ? 2'h0 : !ext.dm_n ? 2'h1 : !ext.io_n ? 2'h2 : 2'h3;
  assign act = !(ext.pm_n && ext.dm_n && ext.io_n && ext.bm_n) && !(ext.rd_n && ext.wr_n);
  // Unwritten words answer with an address pattern, never a plain zero
  assign ext_din = (act && !ext.rd_n) ? mem[{sp, ext.addr}] : rel;
  initial
  begin
    rel = 24'hA5A5A5;
    was = 1'b0;
    acc_n = 0;
    s_len = 0;
    for (int i = 0; i < 65536; i++)
      mem[i] = {8'h5A, 16'(i)};
  end
  always @(posedge clk)
  begin
    rel <= ~rel;
    was <= act;
    if (act)
    begin
      s_addr <= ext.addr;
      s_dout <= ext.dout;
      s_oe   <= ext.doe;
      s_sp   <= sp;
      s_len  <= was ? s_len + 1 : 1;
    end
    if (act && !was)
      acc_n <= acc_n + 1;
    if (act && !ext.wr_n)
      mem[{sp, ext.addr}] <= ext.dout;
  end
endmodule : mmo_ext_mem

// File: dv/test_mmo_decoder.sv
// Purpose: self-checking bench for the memory map overlay decoder
// Assumes: APB waits on pready, core port waits on core_ready and ack
// Notes: every wait is bounded; expectations come from the address map
`timescale 1ns/1ps
module test_mmo_decoder;
  import mmo_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, ok;
  logic        boot_cfg_pin, mode_b_pin, bus_req_pin, boot_done, core_ready;
  logic        fetch_valid, fetch_ready, fetch_ack, run, stack_clear;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [13:0] fetch_addr, start_pc, s_addr, a;
  logic [23:0] fetch_data, ext_din, s_dout, d;
  logic [9:0]  int_mask;
  logic [1:0]  s_sp;
  logic [2:0]  s_oe;
  mmo_req_s    core_req;
  mmo_rsp_s    core_rsp;
  mmo_ext_s    ext;
  int          s_len, acc_n, n0, lat, err_total, checks;
  logic [13:0] oa [4] = '{14'h0010, 14'h1FFF, 14'h2000, 14'h3FDF};
  logic [23:0] od [4] = '{24'h123456, 24'hABCDEF, 24'h00BEAD, 24'h00FACE};
  logic [13:0] ia [5] = '{14'h01FF, 14'h0200, 14'h05FF, 14'h0600, 14'h07FF};

  mmo_decoder i_mmo_decoder (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .boot_cfg_pin, .mode_b_pin, .bus_req_pin, .boot_done, .core_req, .core_ready,
    .core_rsp, .fetch_valid, .fetch_addr, .fetch_ready, .fetch_ack, .fetch_data, .ext,
    .ext_din, .run, .start_pc, .stack_clear, .int_mask
  );
  mmo_ext_mem i_mmo_ext_mem (.clk, .ext, .ext_din, .s_addr, .s_dout, .s_oe, .s_sp, .s_len,
                             .acc_n);

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // A wait that ran out of bound counts as a mismatch
  task automatic lost;
    chk(32'h0, 32'h1);
    close_out();
  endtask : lost

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      lost();
    // One idle edge keeps the select from being driven twice in one step
    @(posedge clk);
  endtask : apb

  task automatic acc(input mmo_space_e s, input logic w, input logic [21:0] ad,
                     input logic [23:0] wd);
    int n;
    core_req <= '{valid: 1'b1, space: s, write: w, addr: ad, wdata: wd};
    n = 0;
    do begin @(posedge clk); n++; end while (core_ready !== 1'b1 && n < 50);
    core_req.valid <= 1'b0;
    lat = 0;
    do begin @(posedge clk); lat++; end while (core_rsp.ack !== 1'b1 && lat < 50);
    q = {8'h00, core_rsp.rdata};
    e = core_rsp.err;
    if (n >= 50 || lat >= 50)
      lost();
  endtask : acc

  // Either one external access in the given space, or a refusal with no strobe
  task automatic post(input logic k, input logic [1:0] sp, input logic [13:0] xa,
                      input int xl);
    chk(32'(e), 32'(!k));
    if (k)
    begin
      chk(32'(s_sp), 32'(sp));
      chk(32'(s_addr), 32'(xa));
      chk(32'(lat), 32'(xl));
      chk(32'(s_len), 32'(xl - 1));
    end
    else
    begin
      chk(32'(acc_n), 32'(n0));
      chk(32'(lat), 32'h1);
    end
  endtask : post

  task automatic reboot(input logic b, input logic m, input logic r);
    boot_cfg_pin <= b;
    mode_b_pin <= m;
    bus_req_pin <= r;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(stack_clear), 32'h1);
    chk(32'(int_mask), 32'h0);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : reboot

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {boot_cfg_pin, mode_b_pin, bus_req_pin, boot_done} = '0;
    core_req = '0;
    fetch_valid = 1'b0;
    fetch_addr = 14'h0000;
    err_total = 0;
    checks = 0;
    reboot(1'b1, 1'b0, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h4);
    chk(32'(run), 32'h0);
    boot_done <= 1'b1;
    @(posedge clk);
    boot_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(run), 32'h1);
    chk(32'(start_pc), 32'(PM_START));
    apb(1'b1, 8'h10, 32'h7F);
    apb(1'b1, 8'h14, 32'h3FF);
    chk(32'(int_mask), 32'h3FF);
    // Reset in mid-run, with a bus request pending
    reboot(1'b1, 1'b0, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h8);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(q, 32'h0);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h18, 32'hF);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h8);
    for (int i = 0; i < 4; i++)
    begin
      n0 = acc_n;
      acc(i < 2 ? SP_PM : SP_DM, 1'b1, 22'(oa[i]), od[i]);
      chk(32'(lat), 32'h1);
      acc(i < 2 ? SP_PM : SP_DM, 1'b0, 22'(oa[i]), 24'h0);
      chk(q, 32'(od[i]));
      chk(32'(acc_n), 32'(n0));
    end
    apb(1'b1, 8'h0C, 32'hF59);
    acc(SP_DM, 1'b0, 22'h3FE3, 24'h0);
    chk(q, 32'hF59);
    fetch_addr <= 14'h1FFF;
    fetch_valid <= 1'b1;
    acc(SP_PM, 1'b0, 22'h0010, 24'h0);
    chk(32'(fetch_ack), 32'h1);
    chk(32'(fetch_data), 32'hABCDEF);
    chk(q, 32'h123456);
    fetch_valid <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      for (int v = 0; v < 4; v++)
      begin
        a = k ? 14'h1ABC : 14'h2345;
        d = k ? 24'h00BEEF : 24'hC3A55A;
        ok = (v == 1) || (v == 2);
        apb(1'b1, k ? 8'h04 : 8'h00, 32'(v));
        n0 = acc_n;
        acc(k ? SP_DM : SP_PM, 1'b1, 22'(a), d);
        post(ok, 2'(k), {v == 2, a[12:0]}, 4);
        if (ok)
          chk(k ? 32'(s_dout[23:8]) : 32'(s_dout), 32'(d));
        acc(k ? SP_DM : SP_PM, 1'b0, 22'(a), 24'h0);
        chk(q, ok ? 32'(d) : 32'h0);
      end
    end
    // Core side write into the control register window
    acc(SP_DM, 1'b1, 22'h3FE1, 24'h000002);
    chk(32'(lat), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h2);
    apb(1'b1, 8'h04, 32'h1);
    for (int w = 0; w < 8; w++)
    begin
      apb(1'b1, 8'h08, 32'(w));
      acc(SP_DM, 1'b0, 22'h0010, 24'h0);
      post(1'b1, 2'h1, 14'h0010, w + 4);
    end
    for (int i = 0; i < 5; i++)
    begin
      a = ia[i];
      acc(SP_IO, 1'b1, 22'(a), 24'h001357);
      post(1'b1, 2'h2, a, 2 * a[10:9] + 5);
      chk(32'(s_dout[23:8]), 32'h1357);
      chk(32'(s_oe), 32'(OE_HI16));
    end
    acc(SP_BYTE, 1'b1, {8'hA5, 14'h1234}, 24'h00005C);
    post(1'b1, 2'h3, 14'h1234, 4);
    chk(32'(s_dout[23:8]), 32'hA55C);
    acc(SP_BYTE, 1'b0, {8'hA5, 14'h1234}, 24'h0);
    chk(q, 32'h5C);
    chk(32'(s_oe), 32'(OE_PAGE));
    reboot(1'b1, 1'b1, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h9);
    chk(32'(fetch_ready), 32'h0);
    acc(SP_PM, 1'b1, 22'h0100, 24'h111111);
    post(1'b1, 2'h0, 14'h0100, 4);
    n0 = acc_n;
    acc(SP_PM, 1'b0, 22'h2100, 24'h0);
    post(1'b0, 2'h0, 14'h0000, 1);
    close_out();
  end
endmodule : test_mmo_decoder
